// File: shared/corl_pkg.sv
/*
 * package of the curtain output release logic: register map, field layout,
 * operating mode and policy encodings, timing constants and carrier types.
 * assumes a 10 MHz system clock and a 32-bit apb register bus.
 */
package corl_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 10000000;
    localparam int unsigned SIMUL_WINDOW_MS   = 500;
    localparam int unsigned SIMUL_WINDOW_CYC  = (CLK_HZ / 1000) * SIMUL_WINDOW_MS;
    localparam int unsigned LINK_EXTRA_US100  = 35;
    localparam int unsigned LINK_EXTRA_CYC    = (CLK_HZ / 10000) * LINK_EXTRA_US100;
    localparam int unsigned RESET_MIN_MS10    = 1;
    localparam int unsigned RESET_MIN_CYC     = ((CLK_HZ / 10) * RESET_MIN_MS10);
    localparam int unsigned RESET_MAX_MS      = 4000;
    localparam int unsigned RESET_MAX_CYC     = (CLK_HZ / 1000) * RESET_MAX_MS;
    localparam int unsigned MAX_RESP_MS       = 99;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_TOL     = 8'h08;
    localparam logic [7:0] ADDR_SCANTIM = 8'h0C;

    localparam int unsigned CTRL_BLANK_EN  = 0;
    localparam int unsigned CTRL_LINK_EN   = 1;
    localparam int unsigned CTRL_ERR_CLR   = 2;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [15:0] SCANTIM_RESET  = 16'h0064;

    // ------------------------------------------------------------
    // modes and policies
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_1 = 3'b001,
        MODE_2 = 3'b010,
        MODE_3 = 3'b011,
        MODE_4 = 3'b100,
        MODE_6 = 3'b110
    } corl_mode_t;

    typedef enum logic [1:0] {
        SINGLE_PASS_POLICY         = 2'b00,
        TWO_PASS_POLICY            = 2'b01,
        ADAPTIVE_MULTI_PASS_POLICY = 2'b10
    } corl_policy_t;

    typedef enum logic [1:0] {
        LNK_OPEN  = 2'b00,
        LNK_WAIT  = 2'b01,
        LNK_OK    = 2'b10,
        LNK_ERROR = 2'b11
    } corl_link_t;

    // one scan result from the beam evaluation
    typedef struct packed {
        logic valid;
        logic violated;
        logic blank_present;
    } corl_scan_t;

endpackage

// File: hdl/corl_release.sv
/*
 * release logic of a light curtain receiver: scan policy, violation run
 * counter, two-channel linkage check, blanking presence and restart
 * interlock, driving two safety switch outputs.
 * assumes scan results and link pins are asynchronous to SYS_CLK_I and
 * are synchronised here; registers are reached over apb.
 */
`timescale 1ns/10ps
`default_nettype none

module corl_release
    import corl_pkg::*;
#(
    parameter int unsigned BEAMS       = 64,
    parameter int unsigned SIMUL_CYC   = SIMUL_WINDOW_CYC,
    parameter int unsigned RST_MIN_CYC = RESET_MIN_CYC,
    parameter int unsigned RST_MAX_CYC = RESET_MAX_CYC
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [2:0]  MODE_I,
    input  wire logic        FUNC_GROUP_SECOND_I,
    input  wire logic        SCAN_VALID_I,
    input  wire logic        SCAN_VIOLATED_I,
    input  wire logic        SCAN_BLANK_PRESENT_I,
    input  wire logic        LINK_CH_A_I,
    input  wire logic        LINK_CH_B_I,
    input  wire logic        RESTART_BUTTON_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             SAFETY_SWITCH_OUTPUT_A_O,
    output logic             SAFETY_SWITCH_OUTPUT_B_O,
    output logic             LINK_ERROR_O
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic       scan_valid_d;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1 <= 10'h000;
            sync2 <= 10'h000;
        end else begin
            sync1 <= {MODE_I, RESTART_BUTTON_I, LINK_CH_B_I, LINK_CH_A_I, SCAN_BLANK_PRESENT_I,
                      SCAN_VIOLATED_I, SCAN_VALID_I, FUNC_GROUP_SECOND_I};
            sync2 <= sync1;
        end
    end

    corl_scan_t scan;
    logic       fg_second;
    logic       ch_a;
    logic       ch_b;
    logic       button;
    logic       scan_strobe;

    assign fg_second     = sync2[0];
    assign scan          = {sync2[1], sync2[2], sync2[3]};  // valid, violated, blank_present
    assign ch_a          = sync2[4];
    assign ch_b          = sync2[5];
    assign button        = sync2[6];
    assign scan_strobe   = scan.valid & ~scan_valid_d;

    // mode pins are wiring straps; read once through the synchroniser after reset release
    logic [2:0] mode_q;
    logic       mode_taken;
    logic [1:0] strap_age;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode_q       <= 3'h0;
            mode_taken   <= 1'b0;
            strap_age    <= 2'h0;
            scan_valid_d <= 1'b0;
        end else begin
            scan_valid_d <= scan.valid;
            if (!mode_taken) begin
                // freeze only after the strap has crossed both flops
                mode_q <= sync2[9:7];
                if (strap_age == 2'h2) begin
                    mode_taken <= 1'b1;
                end else begin
                    strap_age <= strap_age + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic        blank_en;
    logic        link_en;
    logic [15:0] scan_time_us;
    logic [7:0]  tol_count;

    // ------------------------------------------------------------
    // policy selection
    // ------------------------------------------------------------
    corl_policy_t policy;
    logic [7:0]   threshold;
    logic [16:0]  scan_total;
    logic [15:0]  adapt_cnt;

    always_comb begin
        case (mode_q)
            MODE_3:  policy = fg_second ? SINGLE_PASS_POLICY : TWO_PASS_POLICY;
            MODE_4,
            MODE_6:  policy = ADAPTIVE_MULTI_PASS_POLICY;
            default: policy = SINGLE_PASS_POLICY;
        endcase
    end

    // scan time register in microseconds; linkage adds its fixed delay
    // one spare bit so a long scan time plus the linkage delay cannot wrap
    assign scan_total = 17'(scan_time_us) + (link_en ? 17'(LINK_EXTRA_CYC / 10) : 17'h0);
    assign adapt_cnt  = (scan_total == 17'h0) ? 16'h0001 : 16'((MAX_RESP_MS * 1000) / scan_total);

    always_comb begin
        case (policy)
            SINGLE_PASS_POLICY: threshold = 8'h01;
            TWO_PASS_POLICY:    threshold = 8'h02;
            ADAPTIVE_MULTI_PASS_POLICY:
                threshold = (adapt_cnt > 16'h00FF) ? 8'hFF : ((adapt_cnt == 16'h0000) ? 8'h01 : adapt_cnt[7:0]);
            default:            threshold = 8'h01;
        endcase
    end

    // ------------------------------------------------------------
    // violation run counter
    // ------------------------------------------------------------
    logic [7:0] viol_run;
    logic       field_tripped;
    logic       blank_missing;

    // blanked beams are already masked out of the violation flag upstream
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            viol_run      <= 8'h00;
            field_tripped <= 1'b1;
            blank_missing <= 1'b0;
        end else if (scan_strobe) begin
            blank_missing <= blank_en & ~scan.blank_present;
            // nine-bit sum below: a run saturated at 255 must not wrap to zero
            if (!scan.violated) begin
                viol_run      <= 8'h00;
                field_tripped <= 1'b0;
            end else if ({1'b0, viol_run} + 9'h001 >= {1'b0, threshold}) begin
                viol_run      <= threshold;
                field_tripped <= 1'b1;
            end else begin
                viol_run <= viol_run + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // two-channel linkage with simultaneity window
    // ------------------------------------------------------------
    corl_link_t link_state;
    logic [22:0] simul_cnt;
    logic        link_allowed;
    logic        err_clr;

    // contacts or electronic chaining in modes 1-3, checked the same way in each
    assign link_allowed = link_en && (mode_q == MODE_1 || mode_q == MODE_2 || mode_q == MODE_3);

    // upstream device is trusted to detect cross-connections itself
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            link_state <= LNK_OPEN;
            simul_cnt  <= '0;
        end else begin
            case (link_state)
                LNK_OPEN: begin
                    simul_cnt <= '0;
                    if (ch_a && ch_b)
                        link_state <= LNK_OK;
                    else if (ch_a || ch_b)
                        link_state <= LNK_WAIT;
                end
                LNK_WAIT: begin
                    simul_cnt <= simul_cnt + 23'h1;
                    if (ch_a && ch_b)
                        link_state <= LNK_OK;
                    else if (!ch_a && !ch_b)
                        link_state <= LNK_OPEN;
                    else if (simul_cnt >= 23'(SIMUL_CYC - 1))
                        link_state <= LNK_ERROR;
                end
                LNK_OK: begin
                    if (!ch_a || !ch_b)
                        link_state <= (!ch_a && !ch_b) ? LNK_OPEN : LNK_WAIT;
                    simul_cnt <= '0;
                end
                LNK_ERROR: begin
                    // leaves only with both channels open and software clear
                    if (!ch_a && !ch_b && err_clr)
                        link_state <= LNK_OPEN;
                end
                default: link_state <= LNK_OPEN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // restart interlock
    // ------------------------------------------------------------
    logic        interlock_on;
    logic        locked;
    logic [25:0] press_cnt;
    logic        release_ok;

    assign interlock_on = (mode_q == MODE_4) || (mode_q == MODE_6);
    assign release_ok   = (link_state == LNK_OK) || !link_allowed;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            locked    <= 1'b1;
            press_cnt <= '0;
        end else begin
            if (button) begin
                if (press_cnt != 26'h3FFFFFF)
                    press_cnt <= press_cnt + 26'h1;
            end else begin
                press_cnt <= '0;
            end
            // stay locked until the strap is read, or the first edges could unlock
            if (!mode_taken) begin
                locked <= 1'b1;
            end else if (!interlock_on) begin
                locked <= 1'b0;
            end else if (field_tripped || blank_missing) begin
                locked <= 1'b1;
            end else if (!button && press_cnt >= 26'(RST_MIN_CYC) &&
                         press_cnt <= 26'(RST_MAX_CYC)) begin
                locked <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic next_release;

    assign next_release = !field_tripped && !blank_missing && release_ok && !locked;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SAFETY_SWITCH_OUTPUT_A_O <= 1'b0;
            SAFETY_SWITCH_OUTPUT_B_O <= 1'b0;
            LINK_ERROR_O             <= 1'b0;
        end else begin
            SAFETY_SWITCH_OUTPUT_A_O <= next_release;
            SAFETY_SWITCH_OUTPUT_B_O <= next_release;
            LINK_ERROR_O             <= (link_state == LNK_ERROR);
        end
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;

    assign apb_wr  = PSEL_I & PENABLE_I & PWRITE_I;
    // read data is taken in the setup cycle so it stands through the access cycle
    assign apb_rd  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign addr_ok = (PADDR_I == ADDR_CTRL) || (PADDR_I == ADDR_STATUS) ||
                     (PADDR_I == ADDR_TOL) || (PADDR_I == ADDR_SCANTIM);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            blank_en     <= CTRL_RESET[CTRL_BLANK_EN];
            link_en      <= CTRL_RESET[CTRL_LINK_EN];
            err_clr      <= 1'b0;
            scan_time_us <= SCANTIM_RESET;
        end else begin
            err_clr <= 1'b0;
            if (apb_wr && PADDR_I == ADDR_CTRL) begin
                blank_en <= PWDATA_I[CTRL_BLANK_EN];
                link_en  <= PWDATA_I[CTRL_LINK_EN];
                err_clr  <= PWDATA_I[CTRL_ERR_CLR];
            end
            if (apb_wr && PADDR_I == ADDR_SCANTIM)
                scan_time_us <= PWDATA_I[15:0];
        end
    end

    assign tol_count = threshold;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PRDATA_O  <= 32'h0000_0000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_ok;
            if (apb_rd) begin
                case (PADDR_I)
                    ADDR_CTRL:    PRDATA_O <= {30'h0, link_en, blank_en};
                    ADDR_STATUS:  PRDATA_O <= {24'h0, policy, link_state, blank_missing,
                                               field_tripped, locked, SAFETY_SWITCH_OUTPUT_A_O};
                    ADDR_TOL:     PRDATA_O <= {16'h0, viol_run, tol_count};
                    ADDR_SCANTIM: PRDATA_O <= {16'h0, scan_time_us};
                    default:      PRDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: verif/corl_release_assertions.sv
/* checker for the release logic, bound to its ports.
   assumes zero-wait apb and a strap mode held steady outside reset. */
`timescale 1ns/10ps
`default_nettype none
module corl_release_assertions
    import corl_pkg::*;
#(
    parameter int unsigned SIMUL_CYC = SIMUL_WINDOW_CYC
) (
    input wire logic       SYS_CLK_I,
    input wire logic       RESET_N_I,
    input wire logic [2:0] MODE_I,
    input wire logic       SCAN_VALID_I,
    input wire logic       SCAN_VIOLATED_I,
    input wire logic       LINK_CH_A_I,
    input wire logic       LINK_CH_B_I,
    input wire logic       RESTART_BUTTON_I,
    input wire logic       PSEL_I,
    input wire logic       PENABLE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic       PREADY_O,
    input wire logic       PSLVERR_O,
    input wire logic       SAFETY_SWITCH_OUTPUT_A_O,
    input wire logic       SAFETY_SWITCH_OUTPUT_B_O,
    input wire logic       LINK_ERROR_O
);
    // ------------------------------------------------------------
    // helpers: both saturate so a long idle cannot wrap
    // ------------------------------------------------------------
    logic [7:0] skew_cnt;
    logic [3:0] since_rel;
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            skew_cnt <= 8'h00;
        end else if (LINK_CH_A_I == LINK_CH_B_I) begin
            skew_cnt <= 8'h00;
        end else if (skew_cnt != 8'hFF) begin
            skew_cnt <= skew_cnt + 8'h01;
        end
    end
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            since_rel <= 4'hF;
        end else if (RESTART_BUTTON_I) begin
            since_rel <= 4'h0;
        end else if (since_rel != 4'hF) begin
            since_rel <= since_rel + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    chk_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    chk_err_unmapped: assert property (PREADY_O && PADDR_I > 8'h0C |-> PSLVERR_O)
        else $error("unmapped access not refused");
    chk_out_pair: assert property (SAFETY_SWITCH_OUTPUT_A_O == SAFETY_SWITCH_OUTPUT_B_O)
        else $error("safety outputs differ");
    chk_reset_off: assert property ($rose(RESET_N_I) |-> !SAFETY_SWITCH_OUTPUT_A_O [*3])
        else $error("output on right after reset");
    chk_single_off: assert property (
        MODE_I == MODE_1 && $rose(SCAN_VALID_I) && SCAN_VIOLATED_I |-> ##[3:7] !SAFETY_SWITCH_OUTPUT_A_O)
        else $error("single pass did not switch off");
    chk_link_err_off: assert property (LINK_ERROR_O [*3] |-> !SAFETY_SWITCH_OUTPUT_A_O)
        else $error("output on during link error");
    chk_err_late: assert property ($rose(LINK_ERROR_O) |-> {24'h0, skew_cnt} >= SIMUL_CYC)
        else $error("link error inside window");
    chk_restart_rel: assert property (
        (MODE_I == MODE_4 || MODE_I == MODE_6) && $rose(SAFETY_SWITCH_OUTPUT_A_O) |-> since_rel <= 4'hA)
        else $error("release without reset press");
    cov_trip: cover property (MODE_I == MODE_1 && $fell(SAFETY_SWITCH_OUTPUT_A_O));
    cov_link_err: cover property ($rose(LINK_ERROR_O));
    cov_restart: cover property (MODE_I == MODE_4 && $rose(SAFETY_SWITCH_OUTPUT_A_O));
    cov_slverr: cover property (PREADY_O && PSLVERR_O);
endmodule
bind corl_release corl_release_assertions #(.SIMUL_CYC(SIMUL_CYC)) u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .MODE_I(MODE_I),
    .SCAN_VALID_I(SCAN_VALID_I), .SCAN_VIOLATED_I(SCAN_VIOLATED_I),
    .LINK_CH_A_I(LINK_CH_A_I), .LINK_CH_B_I(LINK_CH_B_I), .RESTART_BUTTON_I(RESTART_BUTTON_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .SAFETY_SWITCH_OUTPUT_A_O(SAFETY_SWITCH_OUTPUT_A_O),
    .SAFETY_SWITCH_OUTPUT_B_O(SAFETY_SWITCH_OUTPUT_B_O), .LINK_ERROR_O(LINK_ERROR_O));
`default_nettype wire

// File: verif/corl_upstream.sv
/* upstream two-channel safety device feeding the linkage inputs.
   assumes close and skew are changed just after a clock edge. */
`timescale 1ns/10ps
`default_nettype none
module corl_upstream (
    input  wire logic       clk_i,
    input  wire logic       close_i,
    input  wire logic [7:0] skew_i,
    output logic            ch_a_o,
    output logic            ch_b_o
);
    logic [7:0] age;
    initial begin
        age = 8'h00;
        ch_a_o = 1'b0;
        ch_b_o = 1'b0;
    end
    // two separate channels; ch_b closes skew_i cycles after ch_a; shorts between them are not checked here
    always @(posedge clk_i) begin
        if (!close_i) begin
            age <= 8'h00;
            ch_a_o <= 1'b0;
            ch_b_o <= 1'b0;
        end else begin
            ch_a_o <= 1'b1;
            ch_b_o <= (age >= skew_i);
            if (age != 8'hFF) begin
                age <= age + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/test_curtain_output_release_logic.sv
/* self-checking bench for the release logic.
   assumes shortened window and reset-press parameters, zero-wait apb. */
`timescale 1ns/10ps
`default_nettype none
module test_curtain_output_release_logic
    import corl_pkg::*;
();
    logic        clk = 1'b0, rst_n = 1'b0, fg2 = 1'b0, sv = 1'b0, sviol = 1'b0, sblank = 1'b0;
    logic        btn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, up_close = 1'b0;
    logic [2:0]  mode = 3'h1;
    logic [7:0]  paddr = 8'h00, up_skew = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic        pready, pslverr, out_a, out_b, lerr, ch_a, ch_b, rd_err;
    int          fail_count = 0, n_tests = 0;
    corl_release #(.SIMUL_CYC(20), .RST_MIN_CYC(4), .RST_MAX_CYC(40)) DUT (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .MODE_I(mode), .FUNC_GROUP_SECOND_I(fg2),
        .SCAN_VALID_I(sv), .SCAN_VIOLATED_I(sviol), .SCAN_BLANK_PRESENT_I(sblank),
        .LINK_CH_A_I(ch_a), .LINK_CH_B_I(ch_b), .RESTART_BUTTON_I(btn), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SAFETY_SWITCH_OUTPUT_A_O(out_a),
        .SAFETY_SWITCH_OUTPUT_B_O(out_b), .LINK_ERROR_O(lerr));
    corl_upstream UP (.clk_i(clk), .close_i(up_close), .skew_i(up_skew), .ch_a_o(ch_a), .ch_b_o(ch_b));
    initial begin
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic outs(input logic exp);
        check(32'(out_a), 32'(exp));
        check(32'(out_b), 32'(exp));
    endtask
    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic scan(input logic v, input logic b);
        sviol <= v;
        sblank <= b;
        @(posedge clk);
        sv <= 1'b1;
        repeat (3) @(posedge clk);
        sv <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic rst(input logic [2:0] m, input logic f);
        rst_n <= 1'b0;
        mode <= m;
        fg2 <= f;
        up_close <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_single(input logic [2:0] m, input logic f);
        rst(m, f);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd_data[7:6]), 32'(SINGLE_PASS_POLICY));
        scan(1'b0, 1'b1);
        outs(1'b1);
        scan(1'b1, 1'b1);
        outs(1'b0);
        scan(1'b0, 1'b1);
        outs(1'b1);
        $display("single pass test done");
    endtask
    task automatic t_two();
        rst(MODE_3, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd_data[7:6]), 32'(TWO_PASS_POLICY));
        scan(1'b0, 1'b1);
        scan(1'b1, 1'b1);
        outs(1'b1);
        scan(1'b0, 1'b1);
        scan(1'b1, 1'b1);
        outs(1'b1);
        scan(1'b1, 1'b1);
        outs(1'b0);
        $display("two pass test done");
    endtask
    task automatic t_blank();
        rst(MODE_1, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        scan(1'b0, 1'b1);
        outs(1'b1);
        scan(1'b0, 1'b0);
        outs(1'b0);
        $display("blanking test done");
    endtask
    task automatic t_link();
        rst(MODE_2, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        scan(1'b0, 1'b1);
        outs(1'b0);
        up_skew <= 8'h05;
        up_close <= 1'b1;
        repeat (30) @(posedge clk);
        outs(1'b1);
        up_close <= 1'b0;
        repeat (10) @(posedge clk);
        outs(1'b0);
        up_skew <= 8'h28;
        up_close <= 1'b1;
        repeat (60) @(posedge clk);
        check(32'(lerr), 32'h1);
        outs(1'b0);
        up_close <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1'b1, ADDR_CTRL, 32'h0000_0006);
        repeat (5) @(posedge clk);
        check(32'(lerr), 32'h0);
        up_skew <= 8'h00;
        up_close <= 1'b1;
        repeat (10) @(posedge clk);
        outs(1'b1);
        $display("linkage test done");
    endtask
    task automatic t_adapt(input logic [2:0] m);
        rst(m, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd_data[7:6]), 32'(ADAPTIVE_MULTI_PASS_POLICY));
        apb(1'b0, ADDR_TOL, 32'h0);
        check(32'(rd_data[7:0]), 32'h0000_00FF);
        scan(1'b0, 1'b1);
        outs(1'b0);
        btn <= 1'b1;
        repeat (10) @(posedge clk);
        btn <= 1'b0;
        repeat (8) @(posedge clk);
        outs(1'b1);
        apb(1'b1, ADDR_SCANTIM, 32'h0000_03E8);
        apb(1'b0, ADDR_TOL, 32'h0);
        check(32'(rd_data[7:0]), 32'h0000_0063);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        apb(1'b0, ADDR_TOL, 32'h0);
        check(32'(rd_data[7:0]), 32'h0000_0016);
        scan(1'b1, 1'b1);
        outs(1'b1);
        apb(1'b1, ADDR_SCANTIM, 32'h0000_B3B0);
        scan(1'b1, 1'b1);
        outs(1'b0);
        apb(1'b0, 8'h10, 32'h0);
        check({rd_data[31:1], rd_err}, 32'h1);
        $display("adaptive test done");
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        test_done();
    end
    initial begin
        t_single(MODE_1, 1'b0);
        t_single(MODE_2, 1'b0);
        t_single(MODE_3, 1'b1);
        t_two();
        t_blank();
        t_link();
        t_adapt(MODE_4);
        t_adapt(MODE_6);
        test_done();
    end
endmodule
`default_nettype wire
